// file: include/lcc_cfg.svh
/*
  Constants of the constant-light controller: register offsets, field
  positions, reset values and timing counts.
  Assumes a 40 MHz mclk and an APB master with 32-bit data.
*/
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH

// ****************************************
// register map
// ****************************************
`define LCC_OFS_CFG 8'h00
`define LCC_OFS_SPT 8'h04
`define LCC_OFS_STEP 8'h08
`define LCC_OFS_TIME 8'h0C
`define LCC_OFS_STAT 8'h10

// cfg word bit positions
`define LCC_B_ABS 0
`define LCC_B_LL_EN 1
`define LCC_B_LL_OFF 2
`define LCC_B_SD_LO 3
`define LCC_B_SD_HI 4
`define LCC_B_MIN_ABS 5
`define LCC_B_AFT_OFF 6
`define LCC_B_OFF_ABS 7
`define LCC_B_CANCEL 8
`define LCC_B_START_ABS 9

// reset values
`define LCC_RST_CFG 32'h0000_0307
`define LCC_RST_SPT 32'h0A0A_012C
`define LCC_RST_STEP 32'hFF32_0A04
`define LCC_RST_TIME 32'hFF00_0505

// ****************************************
// telegram codes and timing
// ****************************************
`define LCC_DIM_FULL_DN 8'h01
`define LCC_VAL_MIN 8'h01
`define LCC_VAL_FULL 8'hFF
`define LCC_SD_STD_S 9'd10
`define LCC_CLK_HZ 40000000
`define LCC_TICK_S 1
`define LCC_TICK_CYC (`LCC_CLK_HZ * `LCC_TICK_S)

`endif

// file: include/lcc_pkg.sv
/*
  Types of the constant-light controller: phases, telegram kinds, carriers
  and state records.
  Assumes lcc_cfg.svh is compiled alongside for the constants.
*/
package lcc_pkg;

  // control phases, one-hot
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_START = 5'h02,
    PH_SWAIT = 5'h04,
    PH_MAIN = 5'h08,
    PH_SDWAIT = 5'h10
  } lcc_phase_t;

  typedef enum logic [1:0] {
    TK_SW = 2'h0,
    TK_VAL = 2'h1,
    TK_DIM = 2'h2
  } lcc_kind_t;

  // outgoing bus telegram, valid for one cycle
  typedef struct packed {
    logic valid;
    lcc_kind_t kind;
    logic [7:0] data;
  } lcc_tg_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } lcc_tick_st_t;

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] spt;
    logic [31:0] step;
    logic [31:0] tim;
    lcc_phase_t phase;
    logic [8:0] tmr;
    logic [7:0] out;
    logic [7:0] est;
    logic pres_q;
    lcc_tg_t tg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lcc_st_t;

endpackage : lcc_pkg

// file: rtl/lcc_tick.sv
/*
  One-second timebase for the controller waits.
  Assumes a free-running mclk; CYC may be shortened for simulation.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcc_cfg.svh"

module lcc_tick #(
  parameter int unsigned CYC = `LCC_TICK_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  output logic tick
);

  lcc_pkg::lcc_tick_st_t st;
  lcc_pkg::lcc_tick_st_t next_st;

  // count down, pulse once per period
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'h0000_0000) begin
      next_st.cnt = 32'(CYC - 1);
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : lcc_tick

`default_nettype wire

// file: rtl/lcc_core.sv
/*
  Constant-light controller: startup hand-off, main control with lower
  limit and switch-off brightness, and the end-of-presence step-down.
  Assumes presence and measured brightness come from logic on mclk, and an
  APB master reaches the configuration registers.
*/
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lcc_cfg.svh"

module lcc_core #(
  parameter int unsigned TICK_CYC = `LCC_TICK_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pres,
  input wire logic [15:0] lux,
  output lcc_pkg::lcc_tg_t tg
);

  // ****************************************
  // state and timebase
  // ****************************************
  lcc_pkg::lcc_st_t st;
  lcc_pkg::lcc_st_t next_st;
  logic tick;

  lcc_tick #(.CYC(TICK_CYC)) u_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // ****************************************
  // configuration fields and thresholds
  // ****************************************
  logic abs_fmt, ll_en, ll_off, min_abs, aft_off, off_abs, cancel, start_abs;
  logic [1:0] sd_mode;
  logic [15:0] sp;
  logic [7:0] hy, ah, mstep, llim, pct, rep;
  logic [2:0] code;
  logic [7:0] amt;
  logic [24:0] prod_u, prod_o;
  logic [17:0] up_lim, soff;
  logic ll_hit;
  logic [15:0] pct_scaled;

  assign abs_fmt = st.cfg[`LCC_B_ABS];
  assign ll_en = st.cfg[`LCC_B_LL_EN];
  assign ll_off = st.cfg[`LCC_B_LL_OFF];
  assign sd_mode = st.cfg[`LCC_B_SD_HI:`LCC_B_SD_LO];
  assign min_abs = st.cfg[`LCC_B_MIN_ABS];
  assign aft_off = st.cfg[`LCC_B_AFT_OFF];
  assign off_abs = st.cfg[`LCC_B_OFF_ABS];
  assign cancel = st.cfg[`LCC_B_CANCEL];
  assign start_abs = st.cfg[`LCC_B_START_ABS];
  assign sp = st.spt[15:0];
  assign hy = st.spt[23:16];
  // extra hysteresis only counts with switch-off behaviour selected
  assign ah = ll_off ? st.spt[31:24] : 8'h00;
  // zero step would stall the loop, so one is the floor
  assign mstep = (st.step[7:0] == 8'h00) ? 8'h01 : st.step[7:0];
  assign code = (st.step[2:0] == 3'h0) ? 3'h1 : st.step[2:0];
  // limit clamped into 1..128
  assign llim = (st.step[15:8] == 8'h00) ? 8'h01 :
                (st.step[15:8] > 8'h80) ? 8'h80 : st.step[15:8];
  assign pct = (st.step[23:16] == 8'h00) ? 8'h01 :
               (st.step[23:16] > 8'h64) ? 8'h64 : st.step[23:16];
  assign pct_scaled = 16'((17'(pct) * 17'h000FF) / 17'h00064);
  assign rep = (st.tim[7:0] == 8'h00) ? 8'h01 : st.tim[7:0];
  // relative step code n moves roughly 255 >> (n-1) of full scale
  assign amt = `LCC_VAL_FULL >> (code - 3'h1);

  // upper setpoint limit and switch-off brightness
  assign prod_u = 25'(sp) * 25'(hy);
  assign prod_o = 25'(sp) * 25'({1'b0, hy} + {1'b0, ah});
  assign up_lim = 18'(prod_u / 25'h0000064) + 18'(sp);
  assign soff = 18'(prod_o / 25'h0000064) + 18'(sp);

  // relative limit is inferred from the estimated level
  assign ll_hit = abs_fmt ? (st.out <= llim) : (st.est <= amt);

  // ****************************************
  // next-state logic
  // ****************************************
  // one combinational pass covers bus, timers and phases
  always_comb begin
    next_st = st;
    next_st.tg.valid = 1'b0;
    next_st.pres_q = pres;
    next_st.pready = psel & ~penable;
    next_st.pslverr = 1'b0;

    // apb read data captured in the setup cycle
    if (psel && !penable) begin
      case (paddr)
        `LCC_OFS_CFG: next_st.prdata = st.cfg;
        `LCC_OFS_SPT: next_st.prdata = st.spt;
        `LCC_OFS_STEP: next_st.prdata = st.step;
        `LCC_OFS_TIME: next_st.prdata = st.tim;
        `LCC_OFS_STAT: next_st.prdata = {7'h00, st.tmr, st.out, 3'h0, st.phase};
        default: next_st.prdata = 32'h0000_0000;
      endcase
      next_st.pslverr = (paddr > `LCC_OFS_STAT) || (paddr[1:0] != 2'h0) ||
                        (pwrite && paddr == `LCC_OFS_STAT);
    end
    // writes land at the access edge; unmapped ones are dropped
    if (psel && penable && st.pready && pwrite) begin
      case (paddr)
        `LCC_OFS_CFG: next_st.cfg = pwdata;
        `LCC_OFS_SPT: next_st.spt = pwdata;
        `LCC_OFS_STEP: next_st.step = pwdata;
        `LCC_OFS_TIME: next_st.tim = pwdata;
        default: next_st.cfg = st.cfg;
      endcase
    end

    case (st.phase)
      lcc_pkg::PH_IDLE: begin
        if (pres && !st.pres_q) begin
          next_st.phase = lcc_pkg::PH_START;
        end
      end
      lcc_pkg::PH_START: begin
        if (lux >= sp) begin
          next_st.phase = lcc_pkg::PH_MAIN;
          next_st.tmr = 9'h000;
        end else begin
          next_st.tg.valid = 1'b1;
          next_st.tg.kind = start_abs ? lcc_pkg::TK_VAL : lcc_pkg::TK_SW;
          next_st.tg.data = start_abs ? st.tim[31:24] : 8'h01;
          next_st.out = start_abs ? st.tim[31:24] : `LCC_VAL_FULL;
          next_st.est = next_st.out;
          next_st.tmr = {1'b0, st.tim[15:8]};
          next_st.phase = lcc_pkg::PH_SWAIT;
        end
      end
      lcc_pkg::PH_SWAIT: begin
        if (st.tmr == 9'h000) begin
          next_st.phase = lcc_pkg::PH_MAIN;
        end else if (tick) begin
          next_st.tmr = st.tmr - 9'h001;
        end
      end
      lcc_pkg::PH_MAIN: begin
        if (!pres) begin
          // end of presence opens the step-down
          next_st.tmr = `LCC_SD_STD_S + {1'b0, st.tim[23:16]};
          next_st.tg.valid = 1'b1;
          next_st.phase = lcc_pkg::PH_SDWAIT;
          if (sd_mode == 2'h0) begin
            next_st.tg.kind = off_abs ? lcc_pkg::TK_VAL : lcc_pkg::TK_SW;
            next_st.tg.data = 8'h00;
            next_st.out = 8'h00;
            next_st.est = 8'h00;
            next_st.phase = lcc_pkg::PH_IDLE;
          end else if (sd_mode == 2'h1) begin
            next_st.tg.kind = min_abs ? lcc_pkg::TK_VAL : lcc_pkg::TK_DIM;
            next_st.tg.data = min_abs ? `LCC_VAL_MIN : `LCC_DIM_FULL_DN;
            next_st.out = `LCC_VAL_MIN;
            next_st.est = 8'h00;
          end else begin
            next_st.tg.kind = lcc_pkg::TK_VAL;
            next_st.tg.data = pct_scaled[7:0];
            next_st.out = pct_scaled[7:0];
            next_st.est = pct_scaled[7:0];
          end
        end else if (st.tmr != 9'h000) begin
          // repeat time between telegrams
          if (tick) begin
            next_st.tmr = st.tmr - 9'h001;
          end
        end else begin
          next_st.tmr = {1'b0, rep};
          if ({2'h0, lux} < {2'h0, sp}) begin
            // too dark: step up in the configured format
            if (abs_fmt) begin
              next_st.tg.valid = (st.out != `LCC_VAL_FULL);
              next_st.tg.kind = lcc_pkg::TK_VAL;
              next_st.out = ({1'b0, st.out} + {1'b0, mstep} > 9'h0FF) ?
                            `LCC_VAL_FULL : st.out + mstep;
              next_st.tg.data = next_st.out;
            end else begin
              next_st.tg.valid = 1'b1;
              next_st.tg.kind = lcc_pkg::TK_DIM;
              next_st.tg.data = {4'h0, 1'b1, code};
              next_st.est = ({1'b0, st.est} + {1'b0, amt} > 9'h0FF) ?
                            `LCC_VAL_FULL : st.est + amt;
            end
          end else if ({2'h0, lux} > up_lim) begin
            if (!ll_hit) begin
              // too bright and room left above the limit
              next_st.tg.valid = 1'b1;
              if (abs_fmt) begin
                next_st.tg.kind = lcc_pkg::TK_VAL;
                next_st.out = ({1'b0, st.out} > {1'b0, llim} + {1'b0, mstep}) ?
                              st.out - mstep : llim;
                next_st.tg.data = next_st.out;
              end else begin
                next_st.tg.kind = lcc_pkg::TK_DIM;
                next_st.tg.data = {4'h0, 1'b0, code};
                next_st.est = ({1'b0, st.est} >= {1'b0, amt} + {1'b0, amt}) ?
                              st.est - amt : amt;
              end
            end else if (ll_en && ll_off && {2'h0, lux} >= soff) begin
              next_st.tg.valid = 1'b1;
              next_st.tg.kind = off_abs ? lcc_pkg::TK_VAL : lcc_pkg::TK_SW;
              next_st.tg.data = 8'h00;
              next_st.out = 8'h00;
              next_st.est = 8'h00;
              next_st.phase = lcc_pkg::PH_IDLE;
            end
            // otherwise the limit is ignored or held: no telegram
          end
        end
      end
      lcc_pkg::PH_SDWAIT: begin
        if (pres && cancel && !st.pres_q) begin
          next_st.phase = lcc_pkg::PH_START;
        end else if (st.tmr == 9'h000) begin
          if (aft_off) begin
            next_st.tg.valid = 1'b1;
            next_st.tg.kind = off_abs ? lcc_pkg::TK_VAL : lcc_pkg::TK_SW;
            next_st.tg.data = 8'h00;
            next_st.out = 8'h00;
            next_st.est = 8'h00;
          end
          next_st.phase = pres ? lcc_pkg::PH_START : lcc_pkg::PH_IDLE;
        end else if (tick) begin
          next_st.tmr = st.tmr - 9'h001;
        end
      end
      default: next_st.phase = lcc_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{cfg: `LCC_RST_CFG, spt: `LCC_RST_SPT, step: `LCC_RST_STEP,
              tim: `LCC_RST_TIME, phase: lcc_pkg::PH_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign tg = st.tg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_start_bright;
    st.phase == lcc_pkg::PH_START && lux >= sp |=> st.phase == lcc_pkg::PH_MAIN && !st.tg.valid;
  endproperty
  a_start_bright: assert property (p_start_bright) else $error("bright startup skipped main");

  property p_start_wait;
    st.phase == lcc_pkg::PH_SWAIT && st.tmr != 9'h000 |=> st.phase != lcc_pkg::PH_MAIN;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("main entered before wait ended");

  property p_spacing;
    st.tg.valid && st.phase == lcc_pkg::PH_MAIN |-> st.tmr != 9'h000 ##1 !st.tg.valid;
  endproperty
  a_spacing: assert property (p_spacing) else $error("main telegrams too close");

  property p_no_off_disabled;
    st.phase == lcc_pkg::PH_MAIN && pres && !ll_en |=> st.phase != lcc_pkg::PH_IDLE;
  endproperty
  a_no_off_disabled: assert property (p_no_off_disabled) else $error("off with limit disabled");

  property p_switch_off;
    st.phase == lcc_pkg::PH_MAIN && pres && st.tmr == 9'h000 && ll_hit && ll_en && ll_off &&
      {2'h0, lux} > up_lim && {2'h0, lux} >= soff
      |=> st.tg.valid && st.tg.data == 8'h00 && st.phase == lcc_pkg::PH_IDLE;
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("missed switch-off at limit");

  property p_no_react;
    st.phase == lcc_pkg::PH_MAIN && pres && st.tmr == 9'h000 && ll_hit && !ll_off &&
      {2'h0, lux} > up_lim |=> !st.tg.valid;
  endproperty
  a_no_react: assert property (p_no_react) else $error("output moved at limit");

  property p_sd_off;
    st.phase == lcc_pkg::PH_MAIN && !pres && sd_mode == 2'h0
      |=> st.tg.valid && st.tg.data == 8'h00 && st.phase == lcc_pkg::PH_IDLE;
  endproperty
  a_sd_off: assert property (p_sd_off) else $error("immediate step-down off missing");

  property p_sd_min;
    st.phase == lcc_pkg::PH_MAIN && !pres && sd_mode == 2'h1 && min_abs
      |=> st.tg.valid && st.tg.kind == lcc_pkg::TK_VAL && st.tg.data == `LCC_VAL_MIN;
  endproperty
  a_sd_min: assert property (p_sd_min) else $error("minimum output wrong");

  property p_sd_wait;
    st.phase == lcc_pkg::PH_MAIN && !pres && sd_mode == 2'h2
      |=> st.phase == lcc_pkg::PH_SDWAIT && st.tmr == `LCC_SD_STD_S + {1'b0, $past(st.tim[23:16])};
  endproperty
  a_sd_wait: assert property (p_sd_wait) else $error("step-down wait not loaded");

  property p_cancel;
    st.phase == lcc_pkg::PH_SDWAIT && pres && !st.pres_q && cancel |=> st.phase == lcc_pkg::PH_START;
  endproperty
  a_cancel: assert property (p_cancel) else $error("presence did not cancel step-down");

  property p_ignore;
    st.phase == lcc_pkg::PH_SDWAIT && !cancel && st.tmr != 9'h000 |=> st.phase == lcc_pkg::PH_SDWAIT;
  endproperty
  a_ignore: assert property (p_ignore) else $error("step-down left early");

endmodule : lcc_core

`default_nettype wire

// file: tb/lcc_act_model.sv
/*
  Dimmer actuator model: follows telegrams, turns its level into lux.
  Assumes tg comes registered from lcc_core on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module lcc_act_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire lcc_pkg::lcc_tg_t tg,
  input wire logic [15:0] ambient,
  output logic [15:0] lux
);
  logic [7:0] level;

  // ***
  // dimmer level
  // ***
  // full range down to zero, no floor brightness
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 8'h00;
    end else if (tg.valid === 1'b1) begin
      case (tg.kind)
        lcc_pkg::TK_SW: level <= tg.data[0] ? 8'hFF : 8'h00;
        lcc_pkg::TK_VAL: level <= tg.data;
        default: level <= tg.data[3] ? 8'hFF : 8'h00;
      endcase
    end
  end

  // a shallow slope keeps test margins easy to reckon
  assign lux = ambient + {12'h000, level[7:4]};
endmodule : lcc_act_model
`default_nettype wire

// file: tb/tb_lcc_core.sv
/*
  Bench of lcc_core: apb setup, presence and ambient stimulus, telegram queue.
  Assumes lcc_cfg.svh and lcc_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcc_cfg.svh"

module tb_lcc_core;
  localparam int CYC = 20;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pres = 1'b0;
  logic [15:0] lux;
  logic [15:0] ambient = 16'h0;
  lcc_pkg::lcc_tg_t tg;
  logic [10:0] expq[$];
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_last = 0;
  int t_prev = 0;

  always #12.5 mclk = ~mclk;

  lcc_core #(.TICK_CYC(CYC)) i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pres(pres), .lux(lux), .tg(tg));
  lcc_act_model i_act (.mclk(mclk), .arst_n(arst_n), .tg(tg), .ambient(ambient), .lux(lux));

  // ***
  // checks and closing
  // ***
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // watcher: each pulse takes the oldest note; an unasked pulse meets zero
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      wrap_up();
    end
    if (tg.valid === 1'b1) begin
      t_prev = t_last;
      t_last = cyc;
      chk("telegram", {21'h0, (expq.size() > 0) ? expq.pop_front() : 11'h000}, {21'h0, tg});
    end
  end

  // ***
  // drivers
  // ***
  // holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) n_mismatch++;
  endtask : apb

  // setpoint 100 lux, 10 % + 10 %; limit 128, preset 50 %; repeat 2 s, startup wait 1 s
  task automatic setup(input logic [31:0] cfg);
    @(posedge mclk);
    arst_n <= 1'b0;
    pres <= 1'b0;
    expq.delete();
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b1, `LCC_OFS_SPT, 32'h0A0A_0064);
    apb(1'b1, `LCC_OFS_STEP, 32'h0032_80FF);
    apb(1'b1, `LCC_OFS_TIME, 32'hFF00_0102);
    apb(1'b1, `LCC_OFS_CFG, cfg);
  endtask : setup

  task automatic expect_tg(input logic [10:0] t);
    expq.push_back(t);
  endtask : expect_tg

  // waits for the noted telegrams, bounded
  task automatic drain(input int lim);
    int n = 0;
    while (expq.size() > 0 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    repeat (3) @(posedge mclk);
    chk("missing telegrams", 32'h0, expq.size());
  endtask : drain

  // ***
  // scenarios
  // ***
  initial begin
    logic [31:0] rst[4] = '{`LCC_RST_CFG, `LCC_RST_SPT, `LCC_RST_STEP, `LCC_RST_TIME};
    logic [31:0] sd_cfg[5] = '{32'h201, 32'h281, 32'h269, 32'h209, 32'h2D1};
    logic [10:0] sd_a[5] = '{11'h400, 11'h500, 11'h501, 11'h601, 11'h57F};
    logic [10:0] sd_b[5] = '{11'h000, 11'h000, 11'h400, 11'h000, 11'h500};
    int seed;
    seed = $urandom(54);
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rst[i], rd);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h02, 32'h0);
    chk("misaligned err", 32'h1, {31'h0, er});
    apb(1'b1, `LCC_OFS_STAT, 32'h1F);
    chk("stat write err", 32'h1, {31'h0, er});
    $display("registers done");
    // bright room: straight to main control, silent hold inside the band
    setup(32'h201);
    ambient <= 16'(100 + $urandom % 11);
    pres <= 1'b1;
    repeat (6) @(posedge mclk);
    apb(1'b0, `LCC_OFS_STAT, 32'h0);
    chk("phase", 32'h8, {27'h0, rd[4:0]});
    repeat (5 * CYC) @(posedge mclk);
    $display("direct main done");
    // lower limit: switch-off, no reaction, disabled
    for (int v = 0; v < 3; v++) begin
      setup(v == 0 ? 32'h207 : (v == 1 ? 32'h203 : 32'h201));
      ambient <= 16'd50;
      pres <= 1'b1;
      expect_tg(11'h5FF);
      drain(40 * CYC);
      ambient <= 16'd111;
      expect_tg(11'h580);
      drain(10 * CYC);
      if (v == 0) begin
        repeat (5 * CYC) @(posedge mclk);
        ambient <= 16'd112;
        expect_tg(11'h400);
        drain(5 * CYC);
        apb(1'b0, `LCC_OFS_STAT, 32'h0);
        chk("phase", 32'h1, {27'h0, rd[4:0]});
      end else begin
        if (v == 1) begin
          ambient <= 16'd200;
          repeat (5 * CYC) @(posedge mclk);
        end
        ambient <= 16'd0;
        expect_tg(11'h5FF);
        drain(5 * CYC);
        if (v == 2) chk_rng("repeat gap", CYC, 2 * CYC + 4, t_last - t_prev);
      end
      $display("lower limit variant %0d done", v);
    end
    // relative format, switch-on start: code 1 puts the estimate at the limit at once,
    // so the first bright evaluation must switch off instead of stepping down
    setup(32'h006);
    apb(1'b1, `LCC_OFS_STEP, 32'h0032_8001);
    ambient <= 16'd50;
    pres <= 1'b1;
    expect_tg(11'h401);
    expect_tg(11'h400);
    // brightness rises only after the startup decision has sampled the dark room
    repeat (2) @(posedge mclk);
    ambient <= 16'd111;
    drain(3 * CYC);
    $display("relative limit done");
    // step-down start actions and wait end
    for (int s = 0; s < 5; s++) begin
      setup(sd_cfg[s]);
      ambient <= 16'(100 + $urandom % 11);
      pres <= 1'b1;
      repeat (6) @(posedge mclk);
      pres <= 1'b0;
      expect_tg(sd_a[s]);
      drain(10);
      if (sd_b[s] != 11'h000) begin
        expect_tg(sd_b[s]);
        drain(12 * CYC);
        chk_rng("step-down wait", 9 * CYC, 10 * CYC + 4, t_last - t_prev);
      end else begin
        repeat (12 * CYC) @(posedge mclk);
      end
      $display("step-down case %0d done", s);
    end
    // new presence in the wait: cancel, then ignore
    for (int v = 0; v < 2; v++) begin
      setup(v == 0 ? 32'h369 : 32'h229);
      ambient <= 16'd100;
      pres <= 1'b1;
      repeat (6) @(posedge mclk);
      pres <= 1'b0;
      expect_tg(11'h501);
      drain(10);
      repeat (3 * CYC) @(posedge mclk);
      ambient <= 16'd50;
      pres <= 1'b1;
      expect_tg(11'h5FF);
      drain(12 * CYC);
      if (v == 0) chk_rng("cancel delay", 3 * CYC, 3 * CYC + 12, t_last - t_prev);
      else chk_rng("ignore delay", 9 * CYC, 10 * CYC + 4, t_last - t_prev);
      $display("presence case %0d done", v);
    end
    wrap_up();
  end
endmodule : tb_lcc_core
`default_nettype wire
